// File: inc/pmm_pkg.sv
// Shared constants, states and carriers of the pipe multicast map parser.
// Assumes one clock; every user of it imports the whole package.
package pmm_pkg;

    // ----------------------------------------------------------------
    // Header values
    // ----------------------------------------------------------------
    localparam logic [2:0]  PMM_PKT_SIGNALING = 3'h4;
    localparam logic [7:0]  PMM_SIG_TYPE_MAP  = 8'h01;
    localparam logic [15:0] PMM_SIG_TYPE_EXT  = 16'hFFFF;
    localparam logic [1:0]  PMM_FMT_BINARY    = 2'h0;
    localparam logic [1:0]  PMM_ENC_BINARY    = 2'h0;
    localparam logic [2:0]  PMM_BASE_IPV4     = 3'h0;
    localparam logic [2:0]  PMM_BASE_COMP_IP  = 3'h2;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int          PMM_IDENT_LSB     = 2;
    localparam int          PMM_FLAG_SUB_BIT  = 7;
    localparam int          PMM_FLAG_COMP_BIT = 6;
    localparam logic [1:0]  PMM_LAST_IP_BYTE  = 2'h3;
    localparam logic [1:0]  PMM_LAST_PT_BYTE  = 2'h1;
    localparam logic [7:0]  PMM_ONE_SESSION   = 8'h01;
    localparam int          PMM_FIFO_DEPTH    = 8;

    localparam logic [1:0]  PMM_ERR_NONE      = 2'h0;
    localparam logic [1:0]  PMM_ERR_SHORT     = 2'h1;
    localparam logic [1:0]  PMM_ERR_LONG      = 2'h2;

    typedef enum logic [3:0] {
        S_IDLE      = 4'h0,
        S_PIPE_ID   = 4'h1,
        S_SESS_CNT  = 4'h2,
        S_SRC_IP    = 4'h3,
        S_DST_IP    = 4'h4,
        S_SRC_PORT  = 4'h5,
        S_DST_PORT  = 4'h6,
        S_FLAGS     = 4'h7,
        S_SUBSTREAM = 4'h8,
        S_CONTEXT   = 4'h9,
        S_EMIT      = 4'hA,
        S_SKIP      = 4'hB
    } pmm_state_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  pktType;
        logic [7:0]  sigType;
        logic [15:0] sigTypeExt;
        logic [1:0]  sigFormat;
        logic [1:0]  sigEncoding;
    } pmm_sig_hdr_t;

    typedef struct packed {
        pmm_sig_hdr_t hdr;
        logic         first;
        logic         last;
        logic [7:0]   data;
    } pmm_in_word_t;

    typedef struct packed {
        logic [5:0]  pipeIdent;
        logic [31:0] sourceIpv4;
        logic [31:0] destIpv4;
        logic [15:0] sourcePort;
        logic [15:0] destPort;
        logic        substreamPresent;
        logic        compressed;
        logic [7:0]  substreamIdent;
        logic [7:0]  compContextRef;
        logic [2:0]  expectBaseType;
    } pmm_record_t;

endpackage

// File: hw/pmm_fifo.sv
// Flop-based first-in first-out buffer with valid and ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/1ns
`default_nettype none

module pmm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             inReady_r;
    logic             push;
    logic             pop;

    assign push     = inValid && inReady_r;
    assign pop      = outValid && outReady;
    assign inReady  = inReady_r;
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    for (genvar g = 0; g < DEPTH; g++) begin : gEntry
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                mem_r[g] <= '0;
            end else if (push && (wrPtr_r == AW'(g))) begin
                mem_r[g] <= inData;
            end
        end
    end

    always_comb begin
        unique case ({push, pop})
            2'b10:   count_nxt = count_r + 1'b1;
            2'b01:   count_nxt = count_r - 1'b1;
            default: count_nxt = count_r;
        endcase
    end

    // ----------------------------------------------------------------
    // Pointers and level
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr_r   <= '0;
            rdPtr_r   <= '0;
            count_r   <= '0;
            inReady_r <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            count_r <= count_nxt;
            // Registered so the full flag reaches the source without a long path.
            inReady_r <= (count_nxt != (AW + 1)'(DEPTH));
        end
    end

endmodule // pmm_fifo

`default_nettype wire

// File: hw/pmm_byte_shift.sv
// Keeps the last four bytes of a field so wide fields assemble byte by byte.
// Assumes bytes arrive most significant first.
`timescale 1ns/1ns
`default_nettype none

module pmm_byte_shift (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Byte in
    input  wire logic        shiftEn,
    input  wire logic [7:0]  byteIn,
    // Field including the present byte
    output logic [31:0]      word
);
    logic [31:0] hist_r;

    assign word = {hist_r[23:0], byteIn};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hist_r <= '0;
        end else if (shiftEn) begin
            hist_r <= word;
        end
    end

endmodule // pmm_byte_shift

`default_nettype wire

// File: hw/pmm_map_parser.sv
// Parses the pipe multicast map table out of link-layer signaling packets.
// Assumes the byte stream comes from logic on the same clock, one packet
// framed by first and last, with the signaling header beside each byte.
`timescale 1ns/1ns
`default_nettype none

module pmm_map_parser
    import pmm_pkg::*;
(
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // Link-layer byte stream
    input  wire logic          inValid,
    output logic               inReady,
    input  wire pmm_in_word_t  inWord,
    // Session records
    output logic               recValid,
    input  wire logic          recReady,
    output pmm_record_t        recData,
    // Table status
    output logic               tableDone,
    output logic               tableError,
    output logic [1:0]         errorCause,
    output logic               busy,
    output logic [15:0]        tablesGood
);

    // ----------------------------------------------------------------
    // Buffer in the byte path
    // ----------------------------------------------------------------
    pmm_in_word_t fifoWord;
    logic         fifoValid;
    logic         popByte;

    pmm_fifo #(
        .WIDTH ($bits(pmm_in_word_t)),
        .DEPTH (PMM_FIFO_DEPTH)
    ) uFifo (
        .clock    (clock),
        .rst      (rst),
        .inValid  (inValid),
        .inReady  (inReady),
        .inData   (inWord),
        .outValid (fifoValid),
        .outReady (popByte),
        .outData  (fifoWord)
    );

    // ----------------------------------------------------------------
    // Working state
    // ----------------------------------------------------------------
    pmm_state_t  state_r;
    logic [5:0]  pipeLeft_r;
    logic [7:0]  sessLeft_r;
    logic [1:0]  fieldCnt_r;
    logic        lastSeen_r;
    logic        haveRec_r;
    pmm_record_t cur_r;
    logic        recValid_r;
    pmm_record_t recData_r;
    logic        tableDone_r;
    logic        tableError_r;
    logic [1:0]  errorCause_r;
    logic        busy_r;
    logic [15:0] tablesGood_r;

    logic [7:0]  inB;
    logic        isLast;
    logic        hdrOk;
    logic        startTable;
    logic        inTable;
    logic        toEmit;
    logic        emitGo;
    logic        complete;
    logic        okDone;
    logic        errLong;
    logic        errShort;
    logic        outFree;
    logic [31:0] fieldWord;

    assign inB     = fifoWord.data;
    assign isLast  = fifoWord.last;
    // While a finished record waits in S_EMIT for a free output the parser takes no bytes, so the
    // buffer fills and back-pressure reaches the demultiplexer.
    assign popByte = fifoValid && (state_r != S_EMIT);
    // A new record waits for an empty output, which leaves at least one idle
    // cycle between records at the cost of some throughput.
    assign outFree = !recValid_r;

    pmm_byte_shift uShift (
        .clock   (clock),
        .rst     (rst),
        .shiftEn (popByte),
        .byteIn  (inB),
        .word    (fieldWord)
    );

    // ----------------------------------------------------------------
    // Table recognition
    // ----------------------------------------------------------------
    assign hdrOk = (fifoWord.hdr.pktType == PMM_PKT_SIGNALING)
                && (fifoWord.hdr.sigType == PMM_SIG_TYPE_MAP)
                && (fifoWord.hdr.sigTypeExt == PMM_SIG_TYPE_EXT)
                && (fifoWord.hdr.sigFormat == PMM_FMT_BINARY)
                && (fifoWord.hdr.sigEncoding == PMM_ENC_BINARY);

    // A table starts only on the first byte of a packet.
    assign startTable = (state_r == S_IDLE) && fifoWord.first && hdrOk;

    assign inTable = startTable
                  || ((state_r != S_IDLE) && (state_r != S_SKIP)
                      && (state_r != S_EMIT));

    // Bytes that close a session entry, or a pipe with no sessions.
    always_comb begin
        unique case (state_r)
            S_SESS_CNT:  toEmit = (inB == 8'h00);
            S_FLAGS:     toEmit = !inB[PMM_FLAG_SUB_BIT] && !inB[PMM_FLAG_COMP_BIT];
            S_SUBSTREAM: toEmit = !cur_r.compressed;
            S_CONTEXT:   toEmit = 1'b1;
            default:     toEmit = 1'b0;
        endcase
    end

    assign emitGo   = (state_r == S_EMIT) && (!haveRec_r || outFree);
    assign complete = emitGo && (sessLeft_r <= PMM_ONE_SESSION)
                   && (pipeLeft_r == 6'h00);
    assign okDone   = complete && lastSeen_r;
    assign errLong  = complete && !lastSeen_r;
    assign errShort = (popByte && isLast && inTable && !toEmit)
                   || (emitGo && !complete && lastSeen_r);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r    <= S_IDLE;
            pipeLeft_r <= '0;
            sessLeft_r <= '0;
            fieldCnt_r <= '0;
            lastSeen_r <= 1'b0;
            haveRec_r  <= 1'b0;
        end else if (emitGo) begin
            haveRec_r <= 1'b0;
            if (complete) begin
                state_r <= lastSeen_r ? S_IDLE : S_SKIP;
            end else if (lastSeen_r) begin
                state_r <= S_IDLE;
            end else if (sessLeft_r <= PMM_ONE_SESSION) begin
                pipeLeft_r <= pipeLeft_r - 1'b1;
                state_r    <= S_PIPE_ID;
            end else begin
                sessLeft_r <= sessLeft_r - 1'b1;
                fieldCnt_r <= '0;
                state_r    <= S_SRC_IP;
            end
        end else if (popByte) begin
            if (errShort) begin
                state_r <= S_IDLE;
            end else if (toEmit) begin
                if (state_r == S_SESS_CNT) begin
                    sessLeft_r <= inB;
                end
                lastSeen_r <= isLast;
                haveRec_r  <= (state_r != S_SESS_CNT);
                state_r    <= S_EMIT;
            end else begin
                unique case (state_r)
                    S_IDLE: begin
                        if (startTable) begin
                            pipeLeft_r <= inB[7:PMM_IDENT_LSB];
                            state_r    <= S_PIPE_ID;
                        end else if (fifoWord.first && !isLast) begin
                            state_r <= S_SKIP;
                        end
                    end
                    S_PIPE_ID: begin
                        state_r <= S_SESS_CNT;
                    end
                    S_SESS_CNT: begin
                        sessLeft_r <= inB;
                        fieldCnt_r <= '0;
                        state_r    <= S_SRC_IP;
                    end
                    S_SRC_IP, S_DST_IP: begin
                        fieldCnt_r <= fieldCnt_r + 1'b1;
                        if (fieldCnt_r == PMM_LAST_IP_BYTE) begin
                            fieldCnt_r <= '0;
                            state_r    <= (state_r == S_SRC_IP) ? S_DST_IP : S_SRC_PORT;
                        end
                    end
                    S_SRC_PORT, S_DST_PORT: begin
                        fieldCnt_r <= fieldCnt_r + 1'b1;
                        if (fieldCnt_r == PMM_LAST_PT_BYTE) begin
                            fieldCnt_r <= '0;
                            state_r    <= (state_r == S_SRC_PORT) ? S_DST_PORT : S_FLAGS;
                        end
                    end
                    S_FLAGS: begin
                        state_r <= inB[PMM_FLAG_SUB_BIT] ? S_SUBSTREAM : S_CONTEXT;
                    end
                    S_SUBSTREAM: begin
                        state_r <= S_CONTEXT;
                    end
                    S_SKIP: begin
                        if (isLast) begin
                            state_r <= S_IDLE;
                        end
                    end
                    default: begin
                        state_r <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Session entry capture
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur_r <= '0;
        end else if (popByte) begin
            unique case (state_r)
                S_PIPE_ID: begin
                    cur_r.pipeIdent <= inB[7:PMM_IDENT_LSB];
                end
                S_SRC_IP: begin
                    cur_r.sourceIpv4 <= fieldWord;
                end
                S_DST_IP: begin
                    cur_r.destIpv4 <= fieldWord;
                end
                S_SRC_PORT: begin
                    cur_r.sourcePort <= fieldWord[15:0];
                end
                S_DST_PORT: begin
                    cur_r.destPort <= fieldWord[15:0];
                end
                S_FLAGS: begin
                    cur_r.substreamPresent <= inB[PMM_FLAG_SUB_BIT];
                    cur_r.compressed       <= inB[PMM_FLAG_COMP_BIT];
                    // Absent optional bytes read as zero in the record.
                    cur_r.substreamIdent   <= 8'h00;
                    cur_r.compContextRef   <= 8'h00;
                    cur_r.expectBaseType   <= inB[PMM_FLAG_COMP_BIT]
                                            ? PMM_BASE_COMP_IP
                                            : PMM_BASE_IPV4;
                end
                S_SUBSTREAM: begin
                    cur_r.substreamIdent <= inB;
                end
                S_CONTEXT: begin
                    cur_r.compContextRef <= inB;
                end
                default: begin
                    cur_r <= cur_r;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Record output
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            recValid_r <= 1'b0;
            recData_r  <= '0;
        end else if (emitGo && haveRec_r) begin
            recValid_r <= 1'b1;
            recData_r  <= cur_r;
        end else if (recReady) begin
            recValid_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Table status
    // ----------------------------------------------------------------
    // Records already handed out cannot be recalled; the error pulse tells
    // the consumer to drop what it holds of the current table.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tableDone_r  <= 1'b0;
            tableError_r <= 1'b0;
            errorCause_r <= PMM_ERR_NONE;
            busy_r       <= 1'b0;
            tablesGood_r <= '0;
        end else begin
            tableDone_r  <= okDone;
            tableError_r <= errShort || errLong;
            if (errShort) begin
                errorCause_r <= PMM_ERR_SHORT;
            end else if (errLong) begin
                errorCause_r <= PMM_ERR_LONG;
            end else if (okDone) begin
                errorCause_r <= PMM_ERR_NONE;
            end
            busy_r <= (state_r != S_IDLE) || startTable;
            if (okDone) begin
                tablesGood_r <= tablesGood_r + 1'b1;
            end
        end
    end

    assign recValid   = recValid_r;
    assign recData    = recData_r;
    assign tableDone  = tableDone_r;
    assign tableError = tableError_r;
    assign errorCause = errorCause_r;
    assign busy       = busy_r;
    assign tablesGood = tablesGood_r;

endmodule // pmm_map_parser

`default_nettype wire

// File: sim/pmm_map_parser_monitor.sv
// Concurrent checks on the ports of the map parser.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ns
`default_nettype none

module pmm_map_parser_monitor
    import pmm_pkg::*;
(
    // Clock and reset
    input wire logic         clock,
    input wire logic         rst,
    // Stream and records
    input wire logic         inValid,
    input wire logic         inReady,
    input wire pmm_in_word_t inWord,
    input wire logic         recValid,
    input wire logic         recReady,
    input wire pmm_record_t  recData,
    // Status
    input wire logic         tableDone,
    input wire logic         tableError,
    input wire logic [1:0]   errorCause,
    input wire logic         busy,
    input wire logic [15:0]  tablesGood
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_rec_hold: assert property (recValid && !recReady |=> recValid && $stable(recData))
        else $error("record changed before taken");
    a_rec_gap: assert property (recValid && recReady |=> !recValid)
        else $error("record valid right after handoff");
    a_base_type: assert property (recValid |-> recData.expectBaseType ==
        (recData.compressed ? PMM_BASE_COMP_IP : PMM_BASE_IPV4)) else $error("base type wrong");
    a_sub_absent: assert property (recValid && !recData.substreamPresent |->
        recData.substreamIdent == 8'h00) else $error("absent substream not zero");
    a_ctx_absent: assert property (recValid && !recData.compressed |->
        recData.compContextRef == 8'h00) else $error("absent context not zero");
    a_done_alone: assert property (tableDone |-> !tableError)
        else $error("done and error together");
    a_done_pulse: assert property (tableDone |=> !tableDone)
        else $error("done longer than one cycle");
    a_err_cause: assert property (tableError |-> ##[0:1] errorCause != PMM_ERR_NONE)
        else $error("error without cause");
    a_done_cause: assert property (tableDone |-> ##[0:1] errorCause == PMM_ERR_NONE)
        else $error("good table left a cause");
    a_busy_close: assert property ((tableDone || tableError) |-> busy)
        else $error("table closed while not busy");
    a_good_count: assert property (tableDone |->
        tablesGood == $past(tablesGood) + 16'h0001) else $error("good table count not advanced");

    c_done: cover property (tableDone);
    c_error: cover property (tableError);
    c_stall: cover property (recValid && !recReady ##1 recReady);
endmodule // pmm_map_parser_monitor

bind pmm_map_parser pmm_map_parser_monitor pmm_map_parser_monitor_inst (
    .clock(clock), .rst(rst), .inValid(inValid), .inReady(inReady), .inWord(inWord),
    .recValid(recValid), .recReady(recReady), .recData(recData), .tableDone(tableDone),
    .tableError(tableError), .errorCause(errorCause), .busy(busy), .tablesGood(tablesGood)
);
`default_nettype wire

// File: sim/pmm_record_sink.sv
// Session filter model that takes parsed records, promptly or slowly.
// Assumes one clock; the bench reads the queue of records taken.
`timescale 1ns/1ns
`default_nettype none

module pmm_record_sink
    import pmm_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Pace
    input  wire logic        slow,
    // Records
    input  wire logic        recValid,
    output logic             recReady,
    input  wire pmm_record_t recData
);
    pmm_record_t got[$];
    logic [2:0]  paceCnt;

    // Slow mode takes one record in eight cycles so records wait at the output.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            paceCnt  <= 3'h0;
            recReady <= 1'b0;
        end else begin
            paceCnt  <= paceCnt + 3'h1;
            recReady <= !slow || paceCnt == 3'h7;
            if (recValid && recReady) got.push_back(recData);
        end
    end
endmodule // pmm_record_sink
`default_nettype wire

// File: sim/pmm_map_parser_bench.sv
// Self-checking bench of the map parser: builds tables, sends them, checks records.
// Assumes the package and the record sink model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module pmm_map_parser_bench;
    import pmm_pkg::*;

    `define CHK(g, e) begin checked++; if ((g) !== (e)) begin nFail++; \
        $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end

    logic         clock = 1'b0;
    logic         rst = 1'b1;
    logic         inValid = 1'b0;
    logic         inReady, recValid, recReady, tableDone, tableError, busy, slow = 1'b0;
    pmm_in_word_t inWord = '0;
    pmm_record_t  recData, expRec[$];
    logic [1:0]   errorCause;
    logic [15:0]  tablesGood;
    logic [7:0]   tx[$];
    pmm_sig_hdr_t hdrOk = {PMM_PKT_SIGNALING, PMM_SIG_TYPE_MAP, PMM_SIG_TYPE_EXT,
                           PMM_FMT_BINARY, PMM_ENC_BINARY};
    int           nFail = 0, checked = 0, nDone = 0, nErr = 0;

    always #2 clock = ~clock;
    always @(posedge clock) begin
        if (tableDone === 1'b1) nDone++;
        if (tableError === 1'b1) nErr++;
    end

    pmm_map_parser pmm_map_parser_inst (.clock(clock), .rst(rst), .inValid(inValid),
        .inReady(inReady), .inWord(inWord), .recValid(recValid), .recReady(recReady),
        .recData(recData), .tableDone(tableDone), .tableError(tableError),
        .errorCause(errorCause), .busy(busy), .tablesGood(tablesGood));
    pmm_record_sink pmm_record_sink_inst (.clock(clock), .rst(rst), .slow(slow),
        .recValid(recValid), .recReady(recReady), .recData(recData));

    task print_verdict();
        if (nFail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Session entry: fields most significant byte first, optional bytes by flag.
    task addSess(input logic [5:0] p, input int k);
        pmm_record_t r;
        r = '0;
        r.pipeIdent = p;
        r.sourceIpv4 = 32'hC0A80100 + k;
        r.destIpv4 = 32'hEF010203 + k;
        r.sourcePort = 16'h1F90 + k;
        r.destPort = 16'hABCD - k;
        r.substreamPresent = k[1];
        r.compressed = k[0];
        r.substreamIdent = k[1] ? 8'hA0 + k : 8'h00;
        r.compContextRef = k[0] ? 8'hC0 + k : 8'h00;
        r.expectBaseType = k[0] ? PMM_BASE_COMP_IP : PMM_BASE_IPV4;
        for (int i = 3; i >= 0; i--) tx.push_back(r.sourceIpv4[i*8+:8]);
        for (int i = 3; i >= 0; i--) tx.push_back(r.destIpv4[i*8+:8]);
        for (int i = 1; i >= 0; i--) tx.push_back(r.sourcePort[i*8+:8]);
        for (int i = 1; i >= 0; i--) tx.push_back(r.destPort[i*8+:8]);
        tx.push_back({k[1], k[0], 6'h3F});
        if (k[1]) tx.push_back(r.substreamIdent);
        if (k[0]) tx.push_back(r.compContextRef);
        expRec.push_back(r);
    endtask

    // One table is one whole packet, framed by first and last.
    task sendPkt(input pmm_sig_hdr_t h);
        int n;
        for (int i = 0; i < tx.size(); i++) begin
            inValid <= 1'b1;
            inWord <= {h, i == 0, i == tx.size() - 1, tx[i]};
            n = 0;
            @(posedge clock);
            while (inReady !== 1'b1 && n < 1000) begin
                n++;
                @(posedge clock);
            end
            if (n == 1000) begin nFail++; print_verdict(); end
        end
        inValid <= 1'b0;
        @(posedge clock);
    endtask

    // Waits for the table's end, then checks the records and the counters.
    task finish(input int d, input int e, input logic [1:0] cause);
        int n;
        n = 0;
        while ((nDone + nErr < d + e || pmm_record_sink_inst.got.size() < expRec.size())
               && n < 2000) begin
            n++;
            @(posedge clock);
        end
        if (n == 2000) begin nFail++; print_verdict(); end
        repeat (4) @(posedge clock);
        `CHK(pmm_record_sink_inst.got.size(), expRec.size())
        while (expRec.size() > 0 && pmm_record_sink_inst.got.size() > 0)
            `CHK(pmm_record_sink_inst.got.pop_front(), expRec.pop_front())
        `CHK(nDone, d)
        `CHK(nErr, e)
        `CHK(errorCause, cause)
        tx.delete();
        expRec.delete();
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        slow <= 1'b1;
        tx = '{8'h07, 8'h17, 8'h04};
        for (int k = 0; k < 4; k++) addSess(6'h05, k);
        tx.push_back(8'hFF);
        tx.push_back(8'h00);
        sendPkt(hdrOk);
        finish(1, 0, PMM_ERR_NONE);
        `CHK(tablesGood, 16'h0001)
        slow <= 1'b0;
        for (int v = 0; v < 5; v++) begin
            pmm_sig_hdr_t bad;
            bad = hdrOk;
            case (v)
                0: bad.pktType = 3'h0;
                1: bad.sigType = 8'h02;
                2: bad.sigTypeExt = 16'hFFFE;
                3: bad.sigFormat = 2'h1;
                default: bad.sigEncoding = 2'h2;
            endcase
            tx = '{8'h03, 8'h0B, 8'h01};
            addSess(6'h02, 3);
            expRec.delete();
            sendPkt(bad);
        end
        tx = '{8'h03, 8'h0B, 8'h01};
        addSess(6'h02, 3);
        sendPkt(hdrOk);
        finish(2, 0, PMM_ERR_NONE);
        tx = '{8'h03, 8'h17, 8'h01, 8'h0A, 8'h00, 8'h00, 8'h01, 8'hEF};
        sendPkt(hdrOk);
        finish(2, 1, PMM_ERR_SHORT);
        tx = '{8'h03, 8'h17, 8'h00, 8'hAB};
        sendPkt(hdrOk);
        finish(2, 2, PMM_ERR_LONG);
        `CHK(tablesGood, 16'h0002)
        print_verdict();
    end
endmodule // pmm_map_parser_bench
`default_nettype wire
